// ### rtl/fna_defs.svh
// Constants for the fractional-N accumulator block: offsets, fields, resets.
// Assumes inclusion by the block's single design file only.
`ifndef FNA_DEFS_SVH
`define FNA_DEFS_SVH
// ==========================================================================
// Register byte offsets
`define FNA_OFS_CHAN_A     8'h00
`define FNA_OFS_CHAN_ALT   8'h04
`define FNA_OFS_REF_SETUP  8'h08
`define FNA_OFS_PUMP       8'h0c
`define FNA_OFS_STATUS     8'h10
// ==========================================================================
// Field positions
`define FNA_MAIN_LSB       0
`define FNA_SWAL_LSB       12
`define FNA_NUM_LSB        20
`define FNA_REFD_LSB       0
`define FNA_PS_LSB         12
`define FNA_FRACTION_MODULUS_SELECT_BIT       14
// ==========================================================================
// Reset values and fixed counts
`define FNA_RST_MAIN       12'h001
`define FNA_RST_SWAL       8'h01
`define FNA_RST_NUM        3'h0
`define FNA_RST_REFD       12'h002
`define FNA_RST_PS         2'h0
`define FNA_RST_FRACTION_MODULUS_SELECT       1'b0
`define FNA_RST_PUMP       9'h000
`define FNA_PUMP_CAP       9'h100
`define FNA_SWAL_ZERO_CNT  9'h100
`define FNA_MOD_EIGHT      4'h8
`define FNA_MOD_FIVE       4'h5
`endif

// ### rtl/fna_pkg.sv
// Types shared by the fractional-N accumulator block.
// Assumes nothing of its surroundings.
package fna_pkg;
  // ========================================================================
  // Bus request held from address phase into data phase
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } fna_ahb_req_t;
  // Status word seen by software
  typedef struct packed {
    logic       locked;
    logic       mod_ctrl;
    logic       extend;
    logic [2:0] acc;
  } fna_status_t;
endpackage

// ### rtl/fna_fractional_n_accumulator.sv
// Fractional-N control for the main synthesiser divider, with AHB-Lite registers.
// Assumes reference clock and prescaler output arrive as asynchronous pins,
// an external dual-modulus prescaler and an analogue compensation pump.
//
// How it works
// - Modulus select bit picks modulo 5, or modulo 8 when high.
// - Three-bit numerator is added to the accumulator once per comparison cycle.
// - Sum at or above modulus wraps to remainder and flags overflow.
// - An overflow cycle divides by the total ratio plus exactly one.
// - Extra count comes from one more high-modulus prescaler cycle.
// - Plain ratio is (main plus swallow) times base ratio plus swallow.
// - Pattern repeats every modulus cycles with numerator overflows in it, or modulus overflows if numerator exceeds modulus.
// - Extended cycles fall wherever overflows occur, spread through the pattern.
// - Zero after an overflow marks lock; compensation drives only down pump.
// - Compensation is fixed width, amplitude equal to accumulator value.
// - Compensation gate spans two reference cycles around comparison edge.
// - Reference ratio is divide value times 1, 2, 4 or 8.
// - Pump current code saturates at 256.
// - Numerator loads from either channel word; modulus bit in reference setup.
// - Gate is aligned to the comparison edge so it meets the phase error.
`include "fna_defs.svh"
module fna_fractional_n_accumulator
  import fna_pkg::*;
#(
  parameter int MAIN_W = 12,
  parameter int SWAL_W = 8,
  parameter int REFD_W = 12
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ref_clk_pin,
  input  wire logic        presc_out_pin,
  output logic             prescaler_modulus_ctrl,
  output logic             divided_out,
  output logic             comparison_out,
  output logic             comp_gate,
  output logic      [2:0]  comp_down_amplitude,
  output logic      [8:0]  pump_current_code_out
);
  localparam int CNT_W  = MAIN_W + 1;
  localparam int REFT_W = REFD_W + 3;

  // ========================================================================
  // Accumulator step: returns {overflow, new value}
  function automatic logic [3:0] fna_acc_add(input logic [2:0] a,
                                             input logic [2:0] n,
                                             input logic [3:0] m);
    logic [3:0] s;
    logic       o;
    s = {1'b0, a} + {1'b0, n};
    o = 1'b0;
    if (s >= m) begin
      s = s - m;
      o = 1'b1;
    end
    if (s >= m) begin
      s = s - m;
    end
    return {o, s[2:0]};
  endfunction

  // ========================================================================
  // Registers and state
  fna_ahb_req_t        req_q;
  logic [MAIN_W-1:0]   main_q;
  logic [SWAL_W-1:0]   swal_q;
  logic [2:0]          num_q;
  logic [REFD_W-1:0]   refd_q;
  logic [1:0]          ps_q;
  logic                fraction_modulus_select_q;
  logic [8:0]          pump_q;
  logic [31:0]         hrdata_q;
  logic [2:0]          acc_q;
  logic                ext_q;
  logic                locked_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [8:0]          sw_q;
  logic                mc_q;
  logic                fdiv_q;
  logic [REFT_W-1:0]   ref_cnt_q;
  logic                fcomp_q;
  logic                gate_q;
  logic [2:0]          amp_q;
  logic [2:0]          ref_sync_q;
  logic [2:0]          presc_sync_q;

  logic [3:0]          modv;
  logic [3:0]          acc_next;
  logic                ref_tick;
  logic                presc_tick;
  logic                div_end;
  logic [8:0]          sw_load;
  logic [8:0]          sw_base;
  logic [REFT_W-1:0]   ref_total;
  logic                ref_last;
  logic [31:0]         rd_mux;
  logic [8:0]          pump_wr;
  logic                addr_ok;
  fna_status_t         status;

  // ========================================================================
  // AHB-Lite slave: zero wait, always OKAY, data phase writes
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q <= '{addr: haddr[7:0], write: hwrite, valid: addr_ok};
    end
  end

  // Read data is captured in the address phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `FNA_OFS_CHAN_A, `FNA_OFS_CHAN_ALT: begin
        rd_mux[`FNA_MAIN_LSB +: MAIN_W] = main_q;
        rd_mux[`FNA_SWAL_LSB +: SWAL_W] = swal_q;
        rd_mux[`FNA_NUM_LSB +: 3]       = num_q;
      end
      `FNA_OFS_REF_SETUP: begin
        rd_mux[`FNA_REFD_LSB +: REFD_W] = refd_q;
        rd_mux[`FNA_PS_LSB +: 2]        = ps_q;
        rd_mux[`FNA_FRACTION_MODULUS_SELECT_BIT]           = fraction_modulus_select_q;
      end
      `FNA_OFS_PUMP:   rd_mux[8:0] = pump_q;
      `FNA_OFS_STATUS: rd_mux[5:0] = status;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  assign status = '{locked: locked_q, mod_ctrl: mc_q, extend: ext_q, acc: acc_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  // Either channel word loads counts and numerator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_q <= MAIN_W'(`FNA_RST_MAIN);
      swal_q <= SWAL_W'(`FNA_RST_SWAL);
      num_q  <= `FNA_RST_NUM;
    end else if (req_q.valid && req_q.write &&
                 (req_q.addr == `FNA_OFS_CHAN_A || req_q.addr == `FNA_OFS_CHAN_ALT)) begin
      main_q <= hwdata[`FNA_MAIN_LSB +: MAIN_W];
      swal_q <= hwdata[`FNA_SWAL_LSB +: SWAL_W];
      num_q  <= hwdata[`FNA_NUM_LSB +: 3];
    end
  end

  // Reference setup word holds divide value, postscale and modulus bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refd_q <= REFD_W'(`FNA_RST_REFD);
      ps_q   <= `FNA_RST_PS;
      fraction_modulus_select_q <= `FNA_RST_FRACTION_MODULUS_SELECT;
    end else if (req_q.valid && req_q.write && req_q.addr == `FNA_OFS_REF_SETUP) begin
      refd_q <= hwdata[`FNA_REFD_LSB +: REFD_W];
      ps_q   <= hwdata[`FNA_PS_LSB +: 2];
      fraction_modulus_select_q <= hwdata[`FNA_FRACTION_MODULUS_SELECT_BIT];
    end
  end

  // Pump current code saturates at its ceiling
  assign pump_wr = (hwdata[31:9] != 23'h0 || hwdata[8:0] > `FNA_PUMP_CAP) ?
                   `FNA_PUMP_CAP : hwdata[8:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_q <= `FNA_RST_PUMP;
    end else if (req_q.valid && req_q.write && req_q.addr == `FNA_OFS_PUMP) begin
      pump_q <= pump_wr;
    end
  end

  // ========================================================================
  // Pin synchronisers; third stage feeds edge detection only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_sync_q   <= 3'h0;
      presc_sync_q <= 3'h0;
    end else begin
      ref_sync_q   <= {ref_sync_q[1:0], ref_clk_pin};
      presc_sync_q <= {presc_sync_q[1:0], presc_out_pin};
    end
  end

  assign ref_tick   = ref_sync_q[1] && !ref_sync_q[2];
  assign presc_tick = presc_sync_q[1] && !presc_sync_q[2];

  // ========================================================================
  // Fractional accumulator, stepped at the end of each divide cycle
  assign modv     = fraction_modulus_select_q ? `FNA_MOD_EIGHT : `FNA_MOD_FIVE;
  assign acc_next = fna_acc_add(acc_q, num_q, modv);
  assign div_end  = presc_tick && (cnt_q <= CNT_W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q    <= 3'h0;
      ext_q    <= 1'b0;
      locked_q <= 1'b0;
    end else if (div_end) begin
      acc_q    <= acc_next[2:0];
      ext_q    <= acc_next[3];
      locked_q <= acc_next[3] && (acc_next[2:0] == 3'h0);
    end
  end

  // ========================================================================
  // Programmable divider: swallow phase at high modulus, then main phase
  // Overflow turns one base cycle into a high-modulus cycle; cycle count stays put
  assign sw_base = (swal_q == '0) ? `FNA_SWAL_ZERO_CNT : 9'(swal_q);
  assign sw_load = sw_base + 9'(acc_next[3]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= CNT_W'(1);
      sw_q   <= 9'h000;
      mc_q   <= 1'b0;
      fdiv_q <= 1'b0;
    end else if (div_end) begin
      cnt_q  <= CNT_W'(main_q) + CNT_W'(sw_base);
      sw_q   <= sw_load;
      mc_q   <= (sw_load != 9'h000);
      fdiv_q <= 1'b1;
    end else if (presc_tick) begin
      cnt_q  <= cnt_q - CNT_W'(1);
      fdiv_q <= 1'b0;
      if (sw_q != 9'h000) begin
        sw_q <= sw_q - 9'h001;
        mc_q <= (sw_q != 9'h001);
      end
    end
  end

  // ========================================================================
  // Reference divider and compensation gate
  assign ref_total = REFT_W'(refd_q) << ps_q;
  assign ref_last  = (ref_cnt_q + REFT_W'(1)) >= ref_total;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_q <= '0;
    end else if (ref_tick) begin
      ref_cnt_q <= ref_last ? '0 : ref_cnt_q + REFT_W'(1);
    end
  end

  // Gate covers the last and first reference cycles around the edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcomp_q <= 1'b0;
      gate_q  <= 1'b0;
      amp_q   <= 3'h0;
    end else begin
      fcomp_q <= (ref_cnt_q == '0);
      gate_q  <= ref_last || (ref_cnt_q == '0);
      amp_q   <= (ref_last || ref_cnt_q == '0) ? acc_q : 3'h0;
    end
  end

  // ========================================================================
  // Outputs
  assign hrdata                 = hrdata_q;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign prescaler_modulus_ctrl = mc_q;
  assign divided_out            = fdiv_q;
  assign comparison_out         = fcomp_q;
  assign comp_gate              = gate_q;
  assign comp_down_amplitude    = amp_q;
  assign pump_current_code_out  = pump_q;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_step;
    div_end ##1 1'b1;
  endsequence

  AST_ACC_IN_RANGE: assert property (div_end && acc_q < modv |=> acc_q < $past(modv))
    else $error("accumulator left modulus range");
  AST_ACC_STEP: assert property (div_end |=>
      acc_q == 3'(fna_acc_add($past(acc_q), $past(num_q), $past(modv))))
    else $error("accumulator step wrong");
  AST_ACC_HOLD: assert property (!div_end |=> $stable(acc_q))
    else $error("accumulator moved outside comparison cycle");
  AST_EXT_FLAG: assert property (s_step |->
      ext_q == ({1'b0, $past(acc_q)} + {1'b0, $past(num_q)} >= $past(modv)))
    else $error("overflow flag wrong");
  AST_RELOAD: assert property (div_end |=>
      cnt_q == CNT_W'($past(main_q)) + CNT_W'(sw_q) - CNT_W'(ext_q)
      && sw_q == $past(sw_load))
    else $error("divider reload wrong");
  AST_EXTEND_ONE: assert property (div_end && swal_q != '0 |=>
      sw_q == 9'($past(swal_q)) + 9'(ext_q))
    else $error("extension not exactly one");
  AST_MC_SWALLOW: assert property (div_end |=> mc_q == (sw_q != 9'h000))
    else $error("modulus control mismatch");
  AST_GATE_AROUND_EDGE: assert property ($rose(fcomp_q) && $past(hresetn, 2) |->
      gate_q && $past(gate_q))
    else $error("gate does not straddle comparison edge");
  AST_AMP_GATED: assert property (!gate_q |-> amp_q == 3'h0)
    else $error("compensation outside gate");
  AST_LOCK_ZERO: assert property (locked_q |-> acc_q == 3'h0)
    else $error("lock flag without zero accumulator");
  AST_PUMP_CAP: assert property (pump_q <= `FNA_PUMP_CAP)
    else $error("pump code above ceiling");
  AST_REF_WRAP: assert property (ref_tick && ref_cnt_q != '0 && ref_total > REFT_W'(1)
      |=> ref_cnt_q < ref_total || $changed(ref_total))
    else $error("reference counter beyond ratio");

  // Overflow that leaves zero in the accumulator
  sequence s_overflow_zero;
    div_end && acc_next == 4'h8;
  endsequence

  AST_LOCK_SET: assert property (s_overflow_zero |=> locked_q)
    else $error("lock flag missed after overflow to zero");
  AST_DIV_PULSE: assert property (div_end |=> fdiv_q)
    else $error("divide cycle end not flagged");
  AST_KEEP_CYCLES: assert property (div_end |=>
      cnt_q == CNT_W'($past(main_q)) + CNT_W'($past(sw_base)))
    else $error("overflow changed prescaler cycle count");
  AST_AMP_FOLLOWS_ACC: assert property (gate_q |-> amp_q == $past(acc_q))
    else $error("amplitude not accumulator value");
endmodule

// ### verif/fna_prescaler_model.sv
// Behavioural dual-modulus prescaler on the far side of the divider link.
// Assumes the design's modulus control is a level sampled once per output cycle.
module fna_prescaler_model #(
  parameter int HALF = 4
) (
  input  wire logic hclk,
  input  wire logic prescaler_modulus_ctrl,
  output logic      presc_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Output cycle generator
  // Base mode gives 2*HALF clocks a cycle; base+1 mode stretches the high half
  initial begin
    presc_out_pin <= 1'h0;
    forever begin
      repeat (HALF) @(posedge hclk);
      presc_out_pin <= 1'h1;
      repeat (HALF) @(posedge hclk);
      if (prescaler_modulus_ctrl === 1'h1) @(posedge hclk);
      presc_out_pin <= 1'h0;
    end
  end
endmodule

// ### verif/tb.sv
// Self-checking testbench for the fractional-N accumulator block.
// Assumes a lone AHB-Lite slave and the prescaler model on the divider link.
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Signals
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic        ref_clk_pin = 1'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        presc_out_pin;
  logic        prescaler_modulus_ctrl;
  logic        divided_out;
  logic        comparison_out;
  logic        comp_gate;
  logic [2:0]  comp_down_amplitude;
  logic [8:0]  pump_current_code_out;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_presc = 0;
  int          n_ext = 0;
  int          n_div = 0;
  // ========================================================================
  // Clock, reference pin and instances
  always #10 hclk = ~hclk;
  // Reference pin: ten system clocks a cycle
  always begin
    repeat (5) @(posedge hclk);
    ref_clk_pin <= ~ref_clk_pin;
  end
  fna_fractional_n_accumulator fna_fractional_n_accumulator_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ref_clk_pin(ref_clk_pin), .presc_out_pin(presc_out_pin),
    .prescaler_modulus_ctrl(prescaler_modulus_ctrl), .divided_out(divided_out),
    .comparison_out(comparison_out), .comp_gate(comp_gate),
    .comp_down_amplitude(comp_down_amplitude),
    .pump_current_code_out(pump_current_code_out));
  fna_prescaler_model fna_prescaler_model_i (
    .hclk(hclk), .prescaler_modulus_ctrl(prescaler_modulus_ctrl),
    .presc_out_pin(presc_out_pin));
  // Count prescaler cycles, stretched ones, and divide cycles
  always @(posedge presc_out_pin) begin
    n_presc++;
    if (prescaler_modulus_ctrl === 1'h1) n_ext++;
  end
  always @(posedge divided_out) n_div++;
  // ========================================================================
  // Bus tasks
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(a, 1'h1, d, unused);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'h0, 32'h0, r);
    `CHK(r, e, "register read mismatch")
    `CHK(hresp, 1'h0, "bus error response")
  endtask
  // ========================================================================
  // Scenarios
  // Reset values, shared channel storage, unmapped place
  task automatic t_reset_regs();
    rd_chk(8'h00, 32'h0000_1001);
    rd_chk(8'h04, 32'h0000_1001);
    rd_chk(8'h08, 32'h0000_0002);
    rd_chk(8'h0c, 32'h0000_0000);
    wr(8'h14, 32'hffff_ffff);
    rd_chk(8'h14, 32'h0000_0000);
  endtask
  // Pump code saturates at its cap
  task automatic t_pump();
    wr(8'h0c, 32'h0000_012c);
    rd_chk(8'h0c, 32'h0000_0100);
    `CHK(pump_current_code_out, 9'h100, "pump output not capped")
    wr(8'h0c, 32'h0000_00ff);
    rd_chk(8'h0c, 32'h0000_00ff);
    wr(8'h0c, 32'h0000_0100);
    rd_chk(8'h0c, 32'h0000_0100);
  endtask
  // One full accumulator pattern: prescaler cycles and stretched cycles
  task automatic t_frac(input logic fraction_modulus_select, input logic [2:0] num, input int m,
                        input logic [7:0] a);
    int p0;
    int e0;
    int d0;
    wr(8'h08, {17'h0, fraction_modulus_select, 2'h0, 12'h002});
    wr(a, {9'h0, num, 8'h01, 12'h002});
    rd_chk(a ^ 8'h04, {9'h0, num, 8'h01, 12'h002});
    d0 = n_div;
    wait (n_div == d0 + 2);
    p0 = n_presc;
    e0 = n_ext;
    d0 = n_div;
    wait (n_div == d0 + m);
    `CHK(n_presc - p0, 3 * m, "wrong total division")
    `CHK(n_ext - e0, m + num, "wrong stretched cycle count")
  endtask
  // Comparison pulse and compensation gate over two reference ratios
  task automatic t_gate(input logic [11:0] refdiv, input logic [1:0] ps, input int r);
    int g;
    int c;
    int bad;
    wr(8'h08, {18'h0, ps, refdiv});
    rd_chk(8'h08, {18'h0, ps, refdiv});
    @(posedge comparison_out);
    @(posedge comparison_out);
    g = 0;
    c = 0;
    bad = 0;
    repeat (20 * r) begin
      @(posedge hclk);
      g += (comp_gate === 1'h1);
      c += (comparison_out === 1'h1);
      bad += (comp_gate !== 1'h1 && comp_down_amplitude !== 3'h0);
    end
    `CHK(c, 20, "comparison pulse length")
    `CHK(g, 40, "gate length")
    `CHK(bad, 0, "amplitude outside gate")
  endtask
  // ========================================================================
  // Verdict
  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset_regs();
    t_pump();
    t_frac(1'h1, 3'h3, 8, 8'h04);
    t_frac(1'h1, 3'h7, 8, 8'h00);
    t_frac(1'h1, 3'h0, 8, 8'h04);
    t_frac(1'h0, 3'h2, 5, 8'h00);
    t_frac(1'h0, 3'h4, 5, 8'h04);
    t_gate(12'h004, 2'h0, 4);
    t_gate(12'h002, 2'h1, 4);
    t_gate(12'h002, 2'h2, 8);
    t_gate(12'h001, 2'h3, 8);
    wrap_up();
  end
endmodule
